//--- rtl/mspr_regs.vh
`ifndef MSPR_REGS_VH
`define MSPR_REGS_VH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define MSPR_CTRL_ADDR     16'h103C
// mode/priority register fields
`define MSPR_BIT_BOOT      7
`define MSPR_BIT_SPECIAL_MODE_FLAG      6
`define MSPR_BIT_MDA       5
`define MSPR_BIT_IRV       4
`define MSPR_PSEL_HI       3
`define MSPR_PSEL_LO       0
`define MSPR_PSEL_RST      4'h6

// ---------------------------------------------------------------
// memory map
// ---------------------------------------------------------------
`define MSPR_RAM_RST_PAGE  4'h0
`define MSPR_REG_RST_PAGE  4'h1
`define MSPR_REG_SPAN      16'h0040
`define MSPR_BOOT_BASE     16'hBE00
`define MSPR_BOOT_TOP      16'hBFFF
`define MSPR_EE_SM_BASE    16'hB600
`define MSPR_EE_SM_TOP     16'hB7FF
`define MSPR_EE_LG_RST     4'hF
`define MSPR_EE_LG_OFS     12'h800
`define MSPR_VEC_NORMAL    16'hFFFA
`define MSPR_VEC_SPECIAL   16'hBFFA

// ---------------------------------------------------------------
// eeprom variants and strap timing
// ---------------------------------------------------------------
`define MSPR_EE_NONE       2'h0
`define MSPR_EE_SMALL      2'h1
`define MSPR_EE_LARGE      2'h2
`define MSPR_STRAP_WAIT    2'h3

`endif

//--- rtl/mspr_top.v
`timescale 1ns/10ps
`include "mspr_regs.vh"

module mspr_top #(
  parameter [1:0]  EE_VARIANT = `MSPR_EE_SMALL,
  parameter [15:0] RAM_SPAN   = 16'h0200,
  parameter [15:0] ROM_BASE   = 16'hD000
) (
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [15:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // mode pins
  input  wire        mode_pin_a_in,
  output reg         mode_pin_a_out,
  output reg         mode_pin_a_oe,
  input  wire        mode_pin_b_standby,
  // cpu side
  input  wire        cpu_fetch_first,
  input  wire        cpu_req,
  input  wire [15:0] cpu_addr,
  input  wire        cpu_internal_read,
  // configuration latches and relocation pages
  input  wire        program_rom_enable,
  input  wire        eeprom_enable,
  input  wire [3:0]  eeprom_page_select,
  input  wire [3:0]  ram_page,
  input  wire [3:0]  reg_page,
  input  wire        reloc_valid,
  // decode and mode outputs
  output reg         sel_regs,
  output reg         sel_ram,
  output reg         sel_boot_rom,
  output reg         sel_eeprom,
  output reg         sel_rom,
  output reg         sel_external,
  output reg  [15:0] reset_vector_base,
  output reg         read_visible,
  output reg         eclk_pin_enable,
  output reg  [3:0]  priority_select,
  output reg         special_mode_flag,
  output reg         mode_a_latch,
  output reg         mode_ready
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  reg        pa_meta_reg;
  reg        pa_sync_reg;
  reg        pb_meta_reg;
  reg        pb_sync_reg;
  reg [1:0]  strap_cnt_reg;
  reg        strap_done_reg;
  reg        boot_reg;
  reg        special_mode_flag_reg;
  reg        mda_reg;
  reg        irv_reg;
  reg [3:0]  psel_reg;
  reg        mda_wr_done_reg;
  reg        irv_wr_done_reg;
  reg [3:0]  ee_page_reg;
  reg [7:0]  ctrl_rd;
  reg        hit_ctrl;
  reg        wr_en;
  reg        acc_go;
  reg        in_regs;
  reg        in_ram;
  reg        in_boot;
  reg        in_ee;
  reg        in_rom;
  reg        rom_on;
  reg        free_ram;
  reg        free_boot;
  reg        free_ee;
  reg        free_rom;
  reg [15:0] reg_base;
  reg [15:0] ram_base;
  reg [15:0] ee_base;

  // true when a lies in [base, base+span)
  function in_window;
    input [15:0] a;
    input [15:0] base;
    input [15:0] span;
    reg   [16:0] top;
    begin
      top = {1'b0, base} + {1'b0, span};
      in_window = ({1'b0, a} >= {1'b0, base}) && ({1'b0, a} < top);
    end
  endfunction

  // ---------------------------------------------------------------
  // mode pin synchronisers and strap capture
  // ---------------------------------------------------------------
  // pins are asynchronous; first stage feeds only the second
  // b resets high so the idle sample looks like a normal mode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_meta_reg <= 1'b0;
      pa_sync_reg <= 1'b0;
      pb_meta_reg <= 1'b1;
      pb_sync_reg <= 1'b1;
    end else begin
      pa_meta_reg <= mode_pin_a_in;
      pa_sync_reg <= pa_meta_reg;
      pb_meta_reg <= mode_pin_b_standby;
      pb_sync_reg <= pb_meta_reg;
    end
  end

  // wait for the synchronisers to fill, then latch once
  // the sample is taken a few clocks after release, so the pins
  // must hold their levels until mode_ready rises
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_reg  <= 2'h0;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      if (strap_cnt_reg == `MSPR_STRAP_WAIT)
        strap_done_reg <= 1'b1;
      else
        strap_cnt_reg <= strap_cnt_reg + 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  // the slave answers in the second access cycle; before the straps
  // are latched an access phase simply stretches
  always @* begin
    hit_ctrl = (paddr == `MSPR_CTRL_ADDR);
    acc_go   = psel & penable & ~pready & strap_done_reg;
    wr_en    = psel & penable & pready & pwrite & hit_ctrl;
    ctrl_rd  = {boot_reg, special_mode_flag_reg, mda_reg, irv_reg, psel_reg};
  end

  // pready is a one-cycle pulse and every access takes three cycles;
  // a request raised before the straps are latched waits instead of
  // hanging the master on a missed setup-cycle answer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc_go;
      pslverr <= acc_go & ~hit_ctrl;
      if (acc_go & hit_ctrl & ~pwrite)
        prdata <= {24'h00_0000, ctrl_rd};
      else
        prdata <= 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // mode and priority register
  // ---------------------------------------------------------------
  // write guards read the old special bit, so a write that clears it
  // still lands its other fields under special-mode rules
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_reg        <= 1'b0;
      special_mode_flag_reg        <= 1'b0;
      mda_reg         <= 1'b0;
      irv_reg         <= 1'b0;
      psel_reg        <= `MSPR_PSEL_RST;
      mda_wr_done_reg <= 1'b0;
      irv_wr_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      if (strap_cnt_reg == `MSPR_STRAP_WAIT) begin
        // per-mode reset load
        // pin a high marks expanded and test, pin b low marks special
        special_mode_flag_reg <= ~pb_sync_reg;
        mda_reg  <= pa_sync_reg;
        boot_reg <= ~pb_sync_reg & ~pa_sync_reg;
        irv_reg  <= ~pb_sync_reg & pa_sync_reg;
        psel_reg <= `MSPR_PSEL_RST;
      end
    end else if (wr_en) begin
      psel_reg <= pwdata[`MSPR_PSEL_HI:`MSPR_PSEL_LO];
      // boot bit writable in special only
      if (special_mode_flag_reg)
        boot_reg <= pwdata[`MSPR_BIT_BOOT];
      // clearing is the only way out
      if (special_mode_flag_reg)
        special_mode_flag_reg <= pwdata[`MSPR_BIT_SPECIAL_MODE_FLAG];
      // free in special, once in normal
      if (special_mode_flag_reg || !mda_wr_done_reg) begin
        mda_reg         <= pwdata[`MSPR_BIT_MDA];
        mda_wr_done_reg <= 1'b1;
      end
      if (!irv_wr_done_reg) begin
        irv_reg         <= pwdata[`MSPR_BIT_IRV];
        irv_wr_done_reg <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // eeprom page tracking
  // ---------------------------------------------------------------
  // default top page until relocated
  // the page is only taken while the relocation strobe is high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ee_page_reg <= `MSPR_EE_LG_RST;
    else if (reloc_valid)
      ee_page_reg <= eeprom_page_select;
  end

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  always @* begin
    // pages reset to 0 and 1 upstream of reloc_valid
    reg_base = reloc_valid ? {reg_page, 12'h000}
                           : {`MSPR_REG_RST_PAGE, 12'h000};
    ram_base = reloc_valid ? {ram_page, 12'h000}
                           : {`MSPR_RAM_RST_PAGE, 12'h000};
    ee_base  = {ee_page_reg, `MSPR_EE_LG_OFS};
    in_regs  = in_window(cpu_addr, reg_base, `MSPR_REG_SPAN);
    in_ram   = in_window(cpu_addr, ram_base, RAM_SPAN);
    // boot ROM only when special and enabled
    // both ends of each fixed window are inclusive
    in_boot  = boot_reg & special_mode_flag_reg &
               (cpu_addr >= `MSPR_BOOT_BASE) &&
               (cpu_addr <= `MSPR_BOOT_TOP);
    in_ee    = 1'b0;
    // small eeprom at a fixed window
    if (EE_VARIANT == `MSPR_EE_SMALL)
      in_ee = eeprom_enable && (cpu_addr >= `MSPR_EE_SM_BASE) &&
              (cpu_addr <= `MSPR_EE_SM_TOP);
    // large eeprom on its selected page
    else if (EE_VARIANT == `MSPR_EE_LARGE)
      in_ee = eeprom_enable && (cpu_addr[15:11] == ee_base[15:11]);
    // expanded modes need the enable bit
    rom_on   = ~mda_reg | program_rom_enable;
    in_rom   = rom_on && (cpu_addr >= ROM_BASE);
    // a rank is free only when every rank above it missed
    free_ram  = ~in_regs;
    free_boot = free_ram & ~in_ram;
    free_ee   = free_boot & ~in_boot;
    free_rom  = free_ee & ~in_ee;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_regs     <= 1'b0;
      sel_ram      <= 1'b0;
      sel_boot_rom <= 1'b0;
      sel_eeprom   <= 1'b0;
      sel_rom      <= 1'b0;
      sel_external <= 1'b0;
    end else begin
      sel_regs     <= cpu_req & in_regs;
      sel_ram      <= cpu_req & free_ram & in_ram;
      sel_boot_rom <= cpu_req & free_boot & in_boot;
      sel_eeprom   <= cpu_req & free_ee & in_ee;
      sel_rom      <= cpu_req & free_rom & in_rom;
      sel_external <= cpu_req & free_rom & ~in_rom;
    end
  end

  // ---------------------------------------------------------------
  // mode outputs, strobe pin and bus visibility
  // ---------------------------------------------------------------
  // every output is a flop so the far side sees no decode glitches;
  // the cost is one cycle of latency on each select and mode copy
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_pin_a_out    <= 1'b0;
      mode_pin_a_oe     <= 1'b0;
      reset_vector_base <= `MSPR_VEC_NORMAL;
      read_visible      <= 1'b0;
      eclk_pin_enable   <= 1'b1;
      priority_select   <= `MSPR_PSEL_RST;
      special_mode_flag <= 1'b0;
      mode_a_latch      <= 1'b0;
      mode_ready        <= 1'b0;
    end else begin
      // only latched bits steer the mode
      special_mode_flag <= special_mode_flag_reg;
      mode_a_latch      <= mda_reg;
      mode_ready        <= strap_done_reg;
      priority_select   <= psel_reg;
      // open-drain low on first fetch cycle
      // the pin is never driven high; an outside pull-up sets the level
      mode_pin_a_out    <= 1'b0;
      mode_pin_a_oe     <= strap_done_reg & cpu_fetch_first;
      // vector block by special mode
      // clearing the special bit moves the vector back to the normal block
      reset_vector_base <= special_mode_flag_reg ? `MSPR_VEC_SPECIAL
                                    : `MSPR_VEC_NORMAL;
      // visibility only in expanded modes
      // in single-chip modes of the small and no-eeprom variants the same bit gates the clock pin instead
      read_visible      <= mda_reg & irv_reg & cpu_internal_read;
      // clock gate in single-chip modes
      // the relocatable-eeprom variant keeps the clock pin running
      if (mda_reg || EE_VARIANT == `MSPR_EE_LARGE)
        eclk_pin_enable <= 1'b1;
      else
        eclk_pin_enable <= ~irv_reg;
    end
  end

endmodule // mspr_top

//--- verif/mspr_chk_sva.sv
`timescale 1ns/10ps
// ------------------------------------------------
// decode and mode checker
// ------------------------------------------------
module mspr_chk #(
  parameter [15:0] RAM_SPAN = 16'h0200
) (
  input wire        pclk,
  input wire        presetn,
  input wire        pready,
  input wire        cpu_req,
  input wire [15:0] cpu_addr,
  input wire        cpu_fetch_first,
  input wire        cpu_internal_read,
  input wire        reloc_valid,
  input wire        sel_regs,
  input wire        sel_ram,
  input wire        sel_boot_rom,
  input wire        sel_eeprom,
  input wire        sel_rom,
  input wire        sel_external,
  input wire [15:0] reset_vector_base,
  input wire        read_visible,
  input wire        special_mode_flag,
  input wire        mode_a_latch,
  input wire        mode_ready,
  input wire        mode_pin_a_oe,
  input wire        mode_pin_a_out
);
  // decode vector, highest rank first
  wire [5:0] sel = {sel_regs, sel_ram, sel_boot_rom, sel_eeprom,
                    sel_rom, sel_external};

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_regs_win: assert property (cpu_req && !reloc_valid &&
    cpu_addr[15:6] == 10'h040 |=> sel == 6'h20)
    else $error("register block lost the decode");
  a_ram_low: assert property (cpu_req && !reloc_valid &&
    cpu_addr < RAM_SPAN |=> sel == 6'h10)
    else $error("low page not decoded as ram");
  a_one_hot: assert property (cpu_req |=> $onehot(sel))
    else $error("decode not one-hot");
  a_vec_base: assert property ($rose(mode_ready) |->
    reset_vector_base == (special_mode_flag ? 16'hBFFA : 16'hFFFA))
    else $error("vector base does not follow mode");
  a_special_mode_flag_sticky: assert property (mode_ready &&
    !special_mode_flag |=> !special_mode_flag)
    else $error("special flag set again");
  a_fetch_strobe: assert property (mode_ready &&
    cpu_fetch_first |=> mode_pin_a_oe && !mode_pin_a_out)
    else $error("fetch strobe missing on pin a");
  a_vis_cause: assert property (read_visible |->
    $past(cpu_internal_read) && $past(mode_a_latch))
    else $error("read visibility without cause");
  a_boot_range: assert property (sel_boot_rom |->
    $past(special_mode_flag) && $past(cpu_addr[15:9]) == 7'h5F)
    else $error("boot rom decoded outside its window");
  a_pins_ignored: assert property (mode_ready &&
    $past(mode_ready) && $changed(mode_a_latch) |->
    $past(pready) || $past(pready, 2))
    else $error("mode latch moved without a write");
endmodule // mspr_chk

bind mspr_top mspr_chk #(.RAM_SPAN(RAM_SPAN)) u_chk (.*);

//--- verif/mspr_cpu_model.sv
`timescale 1ns/10ps
// ------------------------------------------------
// cpu core model
// ------------------------------------------------
module mspr_cpu_model (
  input  wire        pclk,
  output reg         cpu_fetch_first,
  output reg         cpu_req,
  output reg  [15:0] cpu_addr,
  output reg         cpu_internal_read
);
  // idle bus at time zero
  initial begin
    cpu_fetch_first = 1'b0;
    cpu_req = 1'b0;
    cpu_addr = 16'h0000;
    cpu_internal_read = 1'b0;
  end

  // one-cycle fetch; released address is inverted so stale data shows
  task access(input [15:0] a, input r);
    begin
      @(posedge pclk);
      cpu_req <= 1'b1;
      cpu_fetch_first <= 1'b1;
      cpu_addr <= a;
      cpu_internal_read <= r;
      @(posedge pclk);
      cpu_req <= 1'b0;
      cpu_fetch_first <= 1'b0;
      cpu_addr <= ~a;
      cpu_internal_read <= 1'b0;
    end
  endtask
endmodule // mspr_cpu_model

//--- verif/mode_select_and_map_priority_bench.sv
`timescale 1ns/10ps
`include "mspr_regs.vh"
// ------------------------------------------------
// bench top
// ------------------------------------------------
module mode_select_and_map_priority_bench;
  reg          pclk, presetn, psel, penable, pwrite, pin_a;
  reg  [15:0]  paddr;
  reg  [31:0]  pwdata, rd, t;
  reg          mode_pin_b_standby, program_rom_enable, eeprom_enable;
  reg          reloc_valid, se, mw, iw;
  reg  [3:0]   eeprom_page_select, ram_page, reg_page;
  reg  [7:0]   er;
  wire [31:0]  prdata;
  wire         pready, pslverr, mode_pin_a_out, mode_pin_a_oe;
  wire         cpu_fetch_first, cpu_req, cpu_internal_read;
  wire [15:0]  cpu_addr, reset_vector_base;
  wire         sel_regs, sel_ram, sel_boot_rom, sel_eeprom, sel_rom;
  wire         sel_external, read_visible, eclk_pin_enable;
  wire         special_mode_flag, mode_a_latch, mode_ready;
  wire [3:0]   priority_select;
  integer      error_cnt, check_count, cyc, i, j;
  // open-drain pin a: strap level unless the design pulls it low
  wire         mode_pin_a_in = pin_a & ~(mode_pin_a_oe & ~mode_pin_a_out);
  reg  [255:0] cor = {16'h1040, 16'h1000, 16'h0000, 16'h01FF,
    16'h0200, 16'h1000, 16'h103F, 16'h1040, 16'hB600, 16'hB7FF,
    16'hB800, 16'hBE00, 16'hBFFF, 16'hCFFF, 16'hD000, 16'hFFFF};

  mspr_top dut (.*);
  mspr_cpu_model cpu (.*);

  // clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      error_cnt = error_cnt + 1;
      summarize;
    end
  end

  // expected decode, rank regs > ram > boot > eeprom > rom
  function [5:0] exp_sel(input [15:0] x);
    begin
      if (x[15:12] == (reloc_valid ? reg_page : 4'h1) && x[11:6] == 6'h00)
        exp_sel = 6'h20;
      else if (x[15:12] == (reloc_valid ? ram_page : 4'h0) && x[11:0] < 12'h200)
        exp_sel = 6'h10;
      else if (x[15:9] == 7'h5F && er[7] && er[6])
        exp_sel = 6'h08;
      else if (x[15:9] == 7'h5B && eeprom_enable)
        exp_sel = 6'h04;
      else if (x >= 16'hD000 && (!er[5] || program_rom_enable))
        exp_sel = 6'h02;
      else
        exp_sel = 6'h01;
    end
  endfunction
  // expected register after a write of d
  function [7:0] nx(input [7:0] r, input [7:0] d);
    begin
      nx[7] = r[6] ? d[7] : r[7];
      nx[6] = r[6] & d[6];
      nx[5] = (r[6] | !mw) ? d[5] : r[5];
      nx[4] = iw ? r[4] : d[4];
      nx[3:0] = d[3:0];
    end
  endfunction

  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [15:0] ad, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr_chk(input [7:0] d);
    begin
      apb(1'b1, `MSPR_CTRL_ADDR, {24'h0, d});
      er = nx(er, d);
      mw = 1'b1;
      iw = 1'b1;
      apb(1'b0, `MSPR_CTRL_ADDR, 32'h0);
      chk(rd, {24'h0, er});
      chk({special_mode_flag, mode_a_latch}, er[6:5]);
      chk(priority_select, er[3:0]);
      chk(eclk_pin_enable, er[5] | !er[4]);
    end
  endtask
  task acc(input [15:0] x, input r);
    begin
      cpu.access(x, r);
      // selects launched at the access edge are read one edge later
      @(posedge pclk);
      chk({sel_regs, sel_ram, sel_boot_rom, sel_eeprom, sel_rom,
           sel_external}, exp_sel(x));
      chk(read_visible, er[5] & er[4] & r);
    end
  endtask
  task summarize;
    begin
      $display("checks=%0d mismatches=%0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  // straps per mode, then decode sweep and register writes
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pin_a} = 0;
    {mode_pin_b_standby, program_rom_enable, eeprom_enable} = 0;
    {reloc_valid, eeprom_page_select, ram_page, reg_page} = 0;
    {error_cnt, check_count, cyc} = 0;
    t = $urandom(32'h3a7a);
    for (i = 0; i < 4; i = i + 1) begin
      t = $urandom;
      presetn <= 1'b0;
      pin_a <= i[0];
      mode_pin_b_standby <= i[1];
      program_rom_enable <= t[0];
      eeprom_enable <= t[1];
      eeprom_page_select <= t[5:2];
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      while (mode_ready !== 1'b1) @(posedge pclk);
      pin_a <= ~i[0];
      mode_pin_b_standby <= ~i[1];
      er = {~i[1] & ~i[0], ~i[1], i[0], ~i[1] & i[0], 4'h6};
      mw = 1'b0;
      iw = 1'b0;
      apb(1'b0, `MSPR_CTRL_ADDR, 32'h0);
      chk(rd, {24'h0, er});
      chk(reset_vector_base, i[1] ? 16'hFFFA : 16'hBFFA);
      chk({special_mode_flag, mode_a_latch}, er[6:5]);
      chk(eclk_pin_enable, er[5] | !er[4]);
      for (j = 0; j < 24; j = j + 1) begin
        t = $urandom;
        reloc_valid <= j > 13;
        ram_page <= j < 16 ? 4'h1 : t[23:20];
        reg_page <= j < 16 ? 4'h1 : t[27:24];
        acc(j < 16 ? cor[j*16 +: 16] : t[15:0], t[16]);
      end
      reloc_valid <= 1'b0;
      apb(1'b1, 16'h1000, 32'hFF);
      chk(se, 1'b1);
      t = $urandom;
      wr_chk(t[7:0]);
      wr_chk(8'h00);
      wr_chk(8'hFF);
      acc(16'hBE00, 1'b1);
      acc(16'hD000, 1'b1);
      $display("mode %0d done", i);
    end
    summarize;
  end
endmodule // mode_select_and_map_priority_bench
